// *** hw/pmb_fifo.sv ***
// Nibble FIFO with registered read data
`timescale 1ns/1ps
module pmb_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             load;

  // Output stage refills whenever it is empty or being taken
  assign in_ready = count < (AW+1)'(DEPTH);
  assign push     = in_valid && in_ready;
  assign load     = (count != '0) && (!out_valid || out_ready);

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // Registered read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule // pmb_fifo

// *** hw/pmb_map.svh ***
// Register map, field positions and timing counts of the transceiver digital core
// How it works
// - Loopback bit routes transmit nibbles to receive
// - Status summary shows loopback in bit 3
// - Selftest sends 9 or 15 bit PRBS
// - Pass flag resets fail, latches on error
// - Continuous bit makes generator transmit nonstop
// - Error count sits in bits 15:8
// - Device drives both MII clocks, nibble synchronous
// - Collisions reported in half duplex only
// - Transmit collision at 10M waits seven bits
// - Receive collision reported at once
// - Heartbeat pulses collision after each 10M half duplex packet
// - Carrier follows squelch or signal detect
// - Half duplex carrier includes transmit activity
// - Thirty-two ones synchronise management port first
// - Resync needed only after bad frame
// - Frames open with start pattern 01
// - Read turnaround: float, then drive zero
// - Status bit 6 reads one
`ifndef PMB_MAP_SVH
`define PMB_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMB_REG_BMC 5'h00
`define PMB_REG_BMS 5'h01
`define PMB_REG_STS 5'h10
`define PMB_REG_PCR 5'h19
`define PMB_REG_STC 5'h1B
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PMB_BMC_LOOP 14
`define PMB_BMC_SPD 13
`define PMB_BMC_ANEN 12
`define PMB_BMC_FDX 8
`define PMB_BMC_RST 16'h3000
`define PMB_BMS_VAL 16'h0040
`define PMB_STS_LOOP 3
`define PMB_STS_FDX 2
`define PMB_STS_SPD10 1
`define PMB_STS_LINK 0
`define PMB_PCR_HB 13
`define PMB_PCR_PRBS15 11
`define PMB_PCR_PASS 10
`define PMB_PCR_START 8
`define PMB_PCR_RST 16'h2000
`define PMB_STC_CONT 5
`define PMB_STC_RST 16'h0000
// ----------------------------------------
// Timing
// ----------------------------------------
`define PMB_CLK_NS 25
`define PMB_PREAMBLE 32
`define PMB_MII10_HALF_NS 200
`define PMB_MII100_HALF_NS 20
`define PMB_HALF_10 (`PMB_MII10_HALF_NS / `PMB_CLK_NS)
`define PMB_HALF_100 ((`PMB_MII100_HALF_NS < `PMB_CLK_NS) ? 1 : `PMB_MII100_HALF_NS / `PMB_CLK_NS)
`define PMB_COL_DLY_NS 700
`define PMB_COL_DLY ((`PMB_COL_DLY_NS + `PMB_CLK_NS - 1) / `PMB_CLK_NS)
`define PMB_HB_GAP_NS 1000
`define PMB_HB_GAP (`PMB_HB_GAP_NS / `PMB_CLK_NS)
`define PMB_HB_LEN_NS 1000
`define PMB_HB_LEN (`PMB_HB_LEN_NS / `PMB_CLK_NS)
`define PMB_BUILTIN_SELFTEST_PKT 8'hFF
`define PMB_BUILTIN_SELFTEST_GAP 8'h18
`define PMB_FIFO_DEPTH 32
`endif

// *** hw/pmb_phy.sv ***
// Transceiver digital core: MII, management slave, loopback and selftest
`timescale 1ns/1ps
`include "pmb_map.svh"
module pmb_phy (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Management pins
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe_n,
  input  wire logic [4:0] phy_addr,
  // MII
  output logic            tx_clk,
  output logic            rx_clk,
  input  wire logic       tx_en,
  input  wire logic [3:0] txd,
  output logic            rx_dv,
  output logic            rx_er,
  output logic      [3:0] rxd,
  output logic            crs,
  output logic            col,
  output logic            tx_space,
  // Line front end
  input  wire logic       line_rx_dv,
  input  wire logic [3:0] line_rxd,
  input  wire logic       signal_detect,
  input  wire logic       squelch_ok,
  input  wire logic       line_tx_ready,
  output logic            line_tx_en,
  output logic      [3:0] line_txd
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [6:0] pin;
  logic [6:0] s1;
  logic [6:0] s2;
  logic [6:0] s3;
  logic [6:0] lvl;
  assign pin = {mdc, mdio_in, tx_en, txd};

  // A change counts once stages two and three agree
  for (genvar g = 0; g < 7; g++) begin : g_sync
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1[g]  <= 1'b0;
        s2[g]  <= 1'b0;
        s3[g]  <= 1'b0;
        lvl[g] <= 1'b0;
      end else begin
        s1[g] <= pin[g];
        s2[g] <= s1[g];
        s3[g] <= s2[g];
        if (s2[g] == s3[g]) begin
          lvl[g] <= s3[g];
        end
      end
    end
  end
  logic mdc_rise;
  logic mdio_bit;
  logic mac_en;
  assign mdc_rise = s2[6] && s3[6] && !lvl[6];
  assign mdio_bit = lvl[5];
  assign mac_en   = lvl[4];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] bmc;
  logic [15:0] pcr;
  logic [15:0] stc;
  logic [7:0]  ecnt;
  logic        builtin_selftest_pass;
  logic        builtin_selftest_fail;
  logic        reg_we;
  logic [4:0]  reg_wa;
  logic [15:0] reg_wd;
  logic        pcr_wr;
  logic        lb;
  logic        spd10;
  logic        fdx;
  logic        hdx;
  logic [15:0] sts_word;
  assign lb     = bmc[`PMB_BMC_LOOP];
  assign spd10  = !bmc[`PMB_BMC_SPD];
  assign fdx    = bmc[`PMB_BMC_FDX];
  assign hdx    = !fdx;
  assign pcr_wr = reg_we && (reg_wa == `PMB_REG_PCR);
  assign sts_word = {12'h000, lb, fdx, spd10, signal_detect};

  // Read decode; unmapped addresses read as zero
  function automatic logic [15:0] rd_word(input logic [4:0] a);
    case (a)
      `PMB_REG_BMC: rd_word = bmc;
      `PMB_REG_BMS: rd_word = `PMB_BMS_VAL;
      `PMB_REG_STS: rd_word = sts_word;
      `PMB_REG_PCR: rd_word = {pcr[15:11], builtin_selftest_pass, pcr[9:0]};
      `PMB_REG_STC: rd_word = {ecnt, stc[7:0]};
      default:      rd_word = 16'h0000;
    endcase
  endfunction

  // Writable registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bmc <= `PMB_BMC_RST;
      pcr <= `PMB_PCR_RST;
      stc <= `PMB_STC_RST;
    end else if (reg_we) begin
      case (reg_wa)
        `PMB_REG_BMC: bmc <= reg_wd;
        `PMB_REG_PCR: pcr <= reg_wd;
        `PMB_REG_STC: stc <= reg_wd;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // MII clocks
  // ----------------------------------------
  logic [3:0] mcnt;
  logic [3:0] half;
  logic       tick_fall;
  assign half      = spd10 ? 4'(`PMB_HALF_10) : 4'(`PMB_HALF_100);
  assign tick_fall = (mcnt >= half - 4'h1) && rx_clk;

  // Both clocks come from one divider so nibbles line up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mcnt   <= 4'h0;
      rx_clk <= 1'b0;
      tx_clk <= 1'b0;
    end else if (mcnt >= half - 4'h1) begin
      mcnt   <= 4'h0;
      rx_clk <= !rx_clk;
      tx_clk <= !rx_clk;
    end else begin
      mcnt <= mcnt + 4'h1;
    end
  end

  // ----------------------------------------
  // Transmit path and selftest
  // ----------------------------------------
  logic       builtin_selftest_run;
  logic       builtin_selftest_on;
  logic [7:0] bcnt;
  logic [3:0] gen_nib;
  logic       chk_ok;
  logic       chk_err;
  logic       f_in_v;
  logic [3:0] f_in_d;
  logic       f_in_r;
  logic       f_out_v;
  logic [3:0] f_out_d;
  logic       f_out_r;
  logic       tx_act;
  assign builtin_selftest_run = pcr[`PMB_PCR_START];
  assign tx_act   = builtin_selftest_run ? builtin_selftest_on : mac_en;
  assign f_in_v   = tick_fall && tx_act;
  assign f_in_d   = builtin_selftest_run ? gen_nib : lvl[3:0];
  assign f_out_r  = lb ? tick_fall : line_tx_ready;

  // Packet mode bursts with gaps; continuous mode never pauses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      builtin_selftest_on <= 1'b0;
      bcnt    <= 8'h00;
    end else if (!builtin_selftest_run) begin
      builtin_selftest_on <= 1'b0;
      bcnt    <= 8'h00;
    end else if (stc[`PMB_STC_CONT]) begin
      builtin_selftest_on <= 1'b1;
    end else if (tick_fall) begin
      bcnt <= bcnt + 8'h01;
      if (builtin_selftest_on && bcnt == `PMB_BUILTIN_SELFTEST_PKT) begin
        builtin_selftest_on <= 1'b0;
        bcnt    <= 8'h00;
      end else if (!builtin_selftest_on && bcnt == `PMB_BUILTIN_SELFTEST_GAP) begin
        builtin_selftest_on <= 1'b1;
        bcnt    <= 8'h00;
      end
    end
  end

  pmb_fifo #(
    .WIDTH (4),
    .DEPTH (`PMB_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (f_in_v),
    .in_data   (f_in_d),
    .in_ready  (f_in_r),
    .out_valid (f_out_v),
    .out_data  (f_out_d),
    .out_ready (f_out_r)
  );

  logic       rx_src_v;
  logic [3:0] rx_src_d;
  logic       line_car;
  logic       rx_act;
  assign line_car = line_rx_dv && (spd10 ? squelch_ok : signal_detect);
  assign rx_src_v = lb ? f_out_v : line_car;
  assign rx_src_d = lb ? f_out_d : line_rxd;
  assign rx_act   = lb ? 1'b0 : line_car;

  logic       chk_step;
  logic [2:0] settle;
  logic       builtin_selftest_ok;
  logic       builtin_selftest_err;
  assign chk_step = tick_fall && builtin_selftest_run && rx_src_v;
  assign builtin_selftest_ok  = chk_ok && settle == 3'h7;
  assign builtin_selftest_err = chk_err && settle == 3'h7;

  // Judgements wait seven nibbles after a control write, so nibbles of the old
  // sequence still in flight are not held against the new one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle <= 3'h0;
    end else if (pcr_wr) begin
      settle <= 3'h0;
    end else if (chk_step && settle != 3'h7) begin
      settle <= settle + 3'h1;
    end
  end

  pmb_prbs u_prbs (
    .clk      (clk),
    .rst      (rst),
    .len15    (pcr[`PMB_PCR_PRBS15]),
    .gen_step (f_in_v && builtin_selftest_run),
    .gen_nib  (gen_nib),
    .chk_step (chk_step),
    .chk_nib  (rx_src_d),
    .chk_ok   (chk_ok),
    .chk_err  (chk_err)
  );

  // Pass flag and error count; an error in the clearing cycle still counts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      builtin_selftest_pass <= 1'b0;
      builtin_selftest_fail <= 1'b0;
      ecnt      <= 8'h00;
    end else begin
      if (builtin_selftest_err) begin
        builtin_selftest_fail <= 1'b1;
        builtin_selftest_pass <= 1'b0;
        ecnt <= pcr_wr ? 8'h01 : (ecnt == 8'hFF ? ecnt : ecnt + 8'h01);
      end else if (pcr_wr) begin
        builtin_selftest_fail <= 1'b0;
        builtin_selftest_pass <= 1'b0;
        ecnt      <= 8'h00;
      end else if (builtin_selftest_ok && !builtin_selftest_fail) begin
        builtin_selftest_pass <= 1'b1;
      end
    end
  end

  // Line side and receive outputs; loopback keeps data off the line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_tx_en <= 1'b0;
      line_txd   <= 4'h0;
      rx_dv      <= 1'b0;
      rx_er      <= 1'b0;
      rxd        <= 4'h0;
      tx_space   <= 1'b1;
    end else begin
      line_tx_en <= !lb && f_out_v && line_tx_ready;
      line_txd   <= f_out_d;
      tx_space   <= f_in_r;
      rx_er      <= 1'b0;
      if (tick_fall) begin
        rx_dv <= rx_src_v;
        rxd   <= rx_src_d;
      end
    end
  end

  // ----------------------------------------
  // Carrier sense and collision
  // ----------------------------------------
  logic       tx_first;
  logic [5:0] ccnt;
  logic [6:0] hcnt;
  logic       tx_act_d;
  logic       hb_pulse;
  logic       col_raw;
  logic       rx_car;
  assign hb_pulse = hcnt > 7'(`PMB_HB_GAP);
  assign col_raw = hdx && tx_act && rx_act
                   && (!(tx_first && spd10) || ccnt == 6'(`PMB_COL_DLY));
  assign rx_car  = lb ? tx_act : line_car;

  // Who started first decides whether the collision is qualified
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_first <= 1'b0;
      ccnt     <= 6'h00;
      tx_act_d <= 1'b0;
    end else begin
      tx_act_d <= tx_act;
      if (!tx_act) begin
        tx_first <= 1'b0;
      end else if (!rx_act) begin
        tx_first <= 1'b1;
      end
      if (!(tx_act && rx_act)) begin
        ccnt <= 6'h00;
      end else if (ccnt != 6'(`PMB_COL_DLY)) begin
        ccnt <= ccnt + 6'h01;
      end
    end
  end

  // Heartbeat: gap, then a pulse, after each 10M half duplex packet
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hcnt <= 7'h00;
    end else if (tx_act_d && !tx_act && spd10 && hdx && pcr[`PMB_PCR_HB]) begin
      hcnt <= 7'h01;
    end else if (hcnt != 7'h00 && hcnt != 7'(`PMB_HB_GAP + `PMB_HB_LEN)) begin
      hcnt <= hcnt + 7'h01;
    end else begin
      hcnt <= 7'h00;
    end
  end

  // MII status outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crs <= 1'b0;
      col <= 1'b0;
    end else begin
      crs <= rx_car || (hdx && tx_act);
      col <= col_raw || (hb_pulse && hdx);
    end
  end

  // ----------------------------------------
  // Management slave
  // ----------------------------------------
  pmb_pkg::pmb_mgmt_type mst;
  logic        synced;
  logic [4:0]  pcnt;
  logic [3:0]  fcnt;
  logic [12:0] hdr;
  logic [15:0] msh;
  logic        hit;
  logic        is_rd;
  assign hit   = hdr[9:5] == phy_addr;
  assign is_rd = hdr[11:10] == 2'b10;

  // Frame walker; sampled on management clock rising edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mst       <= pmb_pkg::M_PRE;
      synced    <= 1'b0;
      pcnt      <= 5'h00;
      fcnt      <= 4'h0;
      hdr       <= 13'h0000;
      msh       <= 16'h0000;
      mdio_out  <= 1'b1;
      mdio_oe_n <= 1'b1;
      reg_we    <= 1'b0;
      reg_wa    <= 5'h00;
      reg_wd    <= 16'h0000;
    end else begin
      reg_we <= 1'b0;
      if (mdc_rise) begin
        case (mst)
          pmb_pkg::M_PRE: begin
            synced <= 1'b0;
            pcnt   <= mdio_bit ? pcnt + 5'h01 : 5'h00;
            if (mdio_bit && pcnt == 5'(`PMB_PREAMBLE - 1)) begin
              synced <= 1'b1;
              mst    <= pmb_pkg::M_IDLE;
            end
          end
          pmb_pkg::M_IDLE: begin
            fcnt <= 4'h0;
            if (!mdio_bit) begin
              mst <= pmb_pkg::M_HDR;
            end
          end
          pmb_pkg::M_HDR: begin
            hdr  <= {hdr[11:0], mdio_bit};
            fcnt <= fcnt + 4'h1;
            if (fcnt == 4'h0 && !mdio_bit) begin
              mst <= pmb_pkg::M_PRE;
            end else if (fcnt == 4'h2 && hdr[0] == mdio_bit) begin
              mst <= pmb_pkg::M_PRE;
            end else if (fcnt == 4'hC) begin
              mst  <= pmb_pkg::M_TA;
              fcnt <= 4'h0;
            end
          end
          pmb_pkg::M_TA: begin
            fcnt <= 4'h1;
            if (fcnt == 4'h0) begin
              if (is_rd && hit) begin
                mdio_out  <= 1'b0;
                mdio_oe_n <= 1'b0;
                msh       <= rd_word(hdr[4:0]);
              end else if (!is_rd && !mdio_bit) begin
                mst <= pmb_pkg::M_PRE;
              end
            end else begin
              fcnt     <= 4'h0;
              mdio_out <= msh[15];
              msh      <= {msh[14:0], 1'b0};
              mst      <= is_rd ? pmb_pkg::M_RD : pmb_pkg::M_WR;
              if (!is_rd && mdio_bit) begin
                mst <= pmb_pkg::M_PRE;
              end
            end
          end
          pmb_pkg::M_RD: begin
            fcnt     <= fcnt + 4'h1;
            mdio_out <= msh[15];
            msh      <= {msh[14:0], 1'b0};
            if (fcnt == 4'hF) begin
              mdio_oe_n <= 1'b1;
              mdio_out  <= 1'b1;
              mst       <= pmb_pkg::M_IDLE;
            end
          end
          pmb_pkg::M_WR: begin
            fcnt <= fcnt + 4'h1;
            msh  <= {msh[14:0], mdio_bit};
            if (fcnt == 4'hF) begin
              reg_we <= hit;
              reg_wa <= hdr[4:0];
              reg_wd <= {msh[14:0], mdio_bit};
              mst    <= pmb_pkg::M_IDLE;
            end
          end
          default: mst <= pmb_pkg::M_PRE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_tx_then_rx;
    (hdx && spd10 && tx_act && !rx_act) ##1 (hdx && spd10 && tx_act && rx_act);
  endsequence
  sequence s_rx_then_tx;
    (hdx && rx_act && !tx_act) ##1 (hdx && rx_act && tx_act);
  endsequence

  property p_lb_quiet;
    lb && $past(lb) |-> !line_tx_en;
  endproperty
  a_lb_quiet: assert property (p_lb_quiet) else $error("line driven in loopback");
  property p_sts_lb;
    mdc_rise && mst == pmb_pkg::M_TA && fcnt == 4'h0 && is_rd && hit
      && hdr[4:0] == `PMB_REG_STS |=> msh[`PMB_STS_LOOP] == $past(lb);
  endproperty
  a_sts_lb: assert property (p_sts_lb) else $error("loopback status wrong");
  property p_fail;
    builtin_selftest_err |=> !builtin_selftest_pass ##1 (!builtin_selftest_pass || $past(pcr_wr, 2));
  endproperty
  a_fail: assert property (p_fail) else $error("pass after error");
  property p_cnt;
    builtin_selftest_err && !pcr_wr && ecnt != 8'hFF |=> ecnt == $past(ecnt) + 8'h01;
  endproperty
  a_cnt: assert property (p_cnt) else $error("error count missed");
  property p_fdx;
    $past(fdx) |-> !col;
  endproperty
  a_fdx: assert property (p_fdx) else $error("collision in full duplex");
  property p_col_tx;
    s_tx_then_rx |=> !col;
  endproperty
  a_col_tx: assert property (p_col_tx) else $error("collision not qualified");
  property p_col_rx;
    s_rx_then_tx |=> col;
  endproperty
  a_col_rx: assert property (p_col_rx) else $error("collision late");
  property p_crs;
    hdx && tx_act |=> crs;
  endproperty
  a_crs: assert property (p_crs) else $error("carrier missing on transmit");
  property p_sync;
    !synced |-> mdio_oe_n;
  endproperty
  a_sync: assert property (p_sync) else $error("drive before preamble");
endmodule // pmb_phy

// *** hw/pmb_pkg.sv ***
// Types shared by the transceiver digital core
package pmb_pkg;
  // Management frame walker, one-hot
  typedef enum logic [5:0] {
    M_PRE  = 6'h01,
    M_IDLE = 6'h02,
    M_HDR  = 6'h04,
    M_TA   = 6'h08,
    M_RD   = 6'h10,
    M_WR   = 6'h20
  } pmb_mgmt_type;
endpackage

// *** hw/pmb_prbs.sv ***
// Selftest pseudo-random nibble generator and self-synchronising checker
`timescale 1ns/1ps
module pmb_prbs (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Mode
  input  wire logic       len15,
  // Generator
  input  wire logic       gen_step,
  output logic      [3:0] gen_nib,
  // Checker
  input  wire logic       chk_step,
  input  wire logic [3:0] chk_nib,
  output logic            chk_ok,
  output logic            chk_err
);
  logic [14:0] gen_st;
  logic [14:0] hist;
  logic [2:0]  warm;
  logic [14:0] next_gen;
  logic [14:0] next_hist;
  logic [3:0]  next_nib;
  logic        miss;

  // Feedback tap of the chosen polynomial
  function automatic logic fb(input logic [14:0] s, input logic l15);
    fb = l15 ? (s[14] ^ s[13]) : (s[8] ^ s[4]);
  endfunction

  // Four serial steps per nibble, first bit in the top position
  always_comb begin
    next_gen  = gen_st;
    next_hist = hist;
    next_nib  = '0;
    miss      = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      next_nib[i] = fb(next_gen, len15);
      next_gen    = {next_gen[13:0], next_nib[i]};
      miss        = miss | (chk_nib[i] != fb(next_hist, len15));
      next_hist   = {next_hist[13:0], chk_nib[i]};
    end
  end

  // Generator state; the seed only needs to be non-zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen_st  <= 15'h7FFF;
      gen_nib <= 4'h0;
    end else if (gen_step) begin
      gen_st  <= next_gen;
      gen_nib <= next_nib;
    end
  end

  // Checker needs four nibbles of history before it judges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist    <= 15'h0000;
      warm    <= 3'h0;
      chk_ok  <= 1'b0;
      chk_err <= 1'b0;
    end else begin
      chk_ok  <= chk_step && warm[2] && !miss;
      chk_err <= chk_step && warm[2] && miss;
      if (chk_step) begin
        hist <= next_hist;
        if (!warm[2]) begin
          warm <= warm + 3'h1;
        end
      end
    end
  end
endmodule // pmb_prbs

// *** verif/phy_mii_mgmt_loopback_builtin_selftest_bench.sv ***
// Bench of the transceiver digital core
`timescale 1ns/1ps
module phy_mii_mgmt_loopback_builtin_selftest_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk, rst, mdc, mdio_in, mdio_out, mdio_oe_n, tx_clk, rx_clk, tx_en, rx_dv;
  logic        rx_er, crs, col, tx_space, line_rx_dv, squelch_ok, line_tx_en, ack, seen;
  logic [3:0]  txd, rxd, line_txd, line_nib;
  logic [3:0]  got [8];
  logic [15:0] rd;
  int          n, err_total, comparisons;
  typedef struct {logic [1:0] op; logic [4:0] ra; logic [15:0] wd, mk, ex;} pmb_row_type;
  pmb_row_type rows [15] = '{
    '{2'h2, 5'h01, 16'h0000, 16'hFFFF, 16'h0040},
    '{2'h2, 5'h00, 16'h0000, 16'hFFFF, 16'h3000},
    '{2'h2, 5'h1B, 16'h0000, 16'hFFFF, 16'h0000},
    '{2'h1, 5'h1B, 16'h0020, 16'h0000, 16'h0000},
    '{2'h2, 5'h1B, 16'h0000, 16'h00FF, 16'h0020},
    '{2'h1, 5'h00, 16'h4100, 16'h0000, 16'h0000},
    '{2'h2, 5'h10, 16'h0000, 16'h000E, 16'h000E},
    '{2'h1, 5'h19, 16'h2900, 16'h0000, 16'h0000},
    '{2'h2, 5'h19, 16'h0000, 16'h0400, 16'h0400},
    '{2'h2, 5'h1B, 16'h0000, 16'hFF00, 16'h0000},
    '{2'h1, 5'h19, 16'h2100, 16'h0000, 16'h0000},
    '{2'h2, 5'h19, 16'h0000, 16'h0400, 16'h0400},
    '{2'h1, 5'h19, 16'h2000, 16'h0000, 16'h0000},
    '{2'h2, 5'h19, 16'h0000, 16'h0400, 16'h0000},
    '{2'h1, 5'h1B, 16'h0000, 16'h0000, 16'h0000}
  };
  pmb_phy pmb_phy_inst (.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(5'h05), .tx_clk(tx_clk),
    .rx_clk(rx_clk), .tx_en(tx_en), .txd(txd), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
    .crs(crs), .col(col), .tx_space(tx_space), .line_rx_dv(line_rx_dv), .line_rxd(4'h0),
    .signal_detect(1'b0), .squelch_ok(squelch_ok), .line_tx_ready(1'b1),
    .line_tx_en(line_tx_en), .line_txd(line_txd));
  pmb_mgr pmb_mgr_inst (.clk(clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Receive nibbles are stable at the rising MII clock
  always @(posedge rx_clk) if (rx_dv === 1'b1 && n < 8) begin
    got[n] = rxd;
    n = n + 1;
  end
  // Anything sent to the line while looped is a fault
  always @(posedge clk) if (line_tx_en === 1'b1) {seen, line_nib} = {1'b1, line_txd};
  task automatic check(input logic [15:0] s, input logic [15:0] e, input string m);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d, err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bounded wait for the next transmit clock rise
  task automatic tx_edge;
    int k;
    k = 0;
    while (tx_clk !== 1'b0 && k < 99) begin @(negedge clk); k++; end
    while (tx_clk !== 1'b1 && k < 99) begin @(negedge clk); k++; end
    if (k >= 99) begin err_total++; stop_test(); end
  endtask
  initial begin
    {rst, tx_en, txd, line_rx_dv, squelch_ok, seen} = {1'b1, 8'h00};
    n = 0;
    repeat (10) @(negedge clk);
    check(16'({mdio_oe_n, col, crs, line_tx_en, tx_space}), 16'h0011, "reset");
    rst = 1'b0;
    pmb_mgr_inst.frame(2'h2, 5'h01, 16'h0000, 1'b0, rd, ack);
    check(16'(ack), 16'h0000, "answer without preamble");
    foreach (rows[i]) begin
      pmb_mgr_inst.frame(rows[i].op, rows[i].ra, rows[i].wd, i == 0, rd, ack);
      if (rows[i].op == 2'h2) check(rd & rows[i].mk, rows[i].ex, "register");
      if (rows[i].ra == 5'h19 && rows[i].wd[8]) repeat (600) @(negedge clk);
    end
    $display("done: registers");
    {n, seen} = 0;
    for (int i = 0; i < 5; i++) begin
      tx_edge();
      tx_en = i < 4;
      txd = 4'hA ^ 4'(i * 5);
    end
    repeat (200) @(negedge clk);
    check(16'(n), 16'h0004, "loop count");
    for (int i = 0; i < 4; i++) check(16'(got[i]), 16'(4'hA ^ 4'(i * 5)), "loop");
    check(16'(seen), 16'h0000, "line sent while looped");
    $display("done: loopback");
    pmb_mgr_inst.frame(2'h0, 5'h01, 16'h0000, 1'b0, rd, ack);
    pmb_mgr_inst.frame(2'h2, 5'h01, 16'h0000, 1'b0, rd, ack);
    check(16'(ack), 16'h0000, "answer after bad opcode");
    pmb_mgr_inst.frame(2'h1, 5'h00, 16'h0000, 1'b1, rd, ack);
    {line_rx_dv, squelch_ok} = 2'h3;
    repeat (3) @(negedge clk);
    check(16'({crs, col}), 16'h0002, "receive carrier");
    tx_en = 1'b1;
    repeat (6) @(negedge clk);
    check(16'(col), 16'h0001, "receive collision");
    {line_rx_dv, tx_en} = 2'h0;
    repeat (60) @(negedge clk);
    check(16'(col), 16'h0001, "heartbeat");
    repeat (40) @(negedge clk);
    check(16'(col), 16'h0000, "heartbeat end");
    tx_en = 1'b1;
    repeat (6) @(negedge clk);
    line_rx_dv = 1'b1;
    repeat (20) @(negedge clk);
    check(16'(col), 16'h0000, "collision too early");
    repeat (15) @(negedge clk);
    check(16'(col), 16'h0001, "transmit collision");
    {line_rx_dv, tx_en} = 2'h0;
    check(16'({rx_er, line_nib, seen}), 16'h001D, "line data");
    $display("done: collision");
    stop_test();
  end
endmodule // phy_mii_mgmt_loopback_builtin_selftest_bench

// *** verif/pmb_mgr.sv ***
// Station manager model driving the management pins
`timescale 1ns/1ps
module pmb_mgr #(
  parameter logic [4:0] ADDR = 5'h05
) (
  // Clock
  input  wire logic clk,
  // Management pins
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe_n
);
  logic drv;
  logic val;
  // Released line reads high through the pull-up
  assign mdio_in = !mdio_oe_n ? mdio_out : (drv ? val : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    val = 1'b1;
  end
  // One bit: 100 ns low, sample, 100 ns high; MDC rests low
  task automatic bit_t(input logic d, input logic o, output logic s);
    drv = o;
    val = d;
    repeat (4) @(negedge clk);
    s = mdio_in;
    mdc = 1'b1;
    repeat (4) @(negedge clk);
    mdc = 1'b0;
  endtask
  // Idle bit, optional preamble left to the pull-up, then the frame
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       input logic pre, output logic [15:0] rd, output logic ack);
    logic [31:0] f;
    logic        s;
    f = {2'h1, op, ADDR, ra, 2'h2, wd};
    ack = 1'b0;
    for (int i = 0; i < (pre ? 33 : 1); i++) bit_t(1'b1, 1'b0, s);
    for (int i = 31; i >= 0; i--) begin
      bit_t(f[i], !(op == 2'h2 && i < 18), s);
      if (i == 17) ack = s;
      if (i == 16) ack = ack & !s;
      if (i < 16) rd[i] = s;
    end
    drv = 1'b0;
  endtask
endmodule // pmb_mgr
